//--- inc/lil_pkg.sv
// Package with the constants and types of the latched indicator lamp logic.
package lil_pkg;
    localparam int COLS = 2;
    localparam int ROWS = 8;
    localparam int SLOTS = 5;
    localparam int NUM_SIG = 32;
    localparam int SEL_W = 6;
    localparam int CODE_W = 3;
    localparam int MODE_W = 2;
    localparam int CNT_W = 32;

    // Slot selector value that means no signal is assigned.
    localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;
    localparam logic [SEL_W-1:0] SEL_MAX = 6'h20;

    // Lamp colour codes, shared by the lit and unlit settings.
    localparam logic [CODE_W-1:0] CODE_OFF = 3'h0;
    localparam logic [CODE_W-1:0] CODE_GREEN = 3'h1;
    localparam logic [CODE_W-1:0] CODE_RED = 3'h2;
    localparam logic [CODE_W-1:0] CODE_RED_FLASH = 3'h3;
    localparam logic [CODE_W-1:0] CODE_GREEN_FLASH = 3'h4;

    // Latch modes of a lamp.
    localparam logic [MODE_W-1:0] MODE_FOLLOW = 2'h0;
    localparam logic [MODE_W-1:0] MODE_HOLD = 2'h1;
    localparam logic [MODE_W-1:0] MODE_HOLD_ALARM = 2'h2;

    // Flash timing: half a flash period at the 10 MHz system clock.
    localparam int CLK_PERIOD_NS = 100;
    localparam int FLASH_HALF_MS = 500;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;

    typedef logic [SEL_W-1:0] lil_sel_t;
    typedef logic [CODE_W-1:0] lil_code_t;
    typedef logic [MODE_W-1:0] lil_mode_t;
    typedef logic [NUM_SIG-1:0] lil_sig_t;
endpackage

//--- inc/lil_eval_if.sv
// Interface carrying one lamp's trigger settings to its evaluator and the result back.
`timescale 1ns/1ps
interface lil_eval_if;
    import lil_pkg::*;
    lil_sig_t sig;
    lil_sel_t [SLOTS-1:0] sel;
    logic [SLOTS-1:0] inv;
    logic active;
    logic assigned;
    modport drv (output sig, output sel, output inv, input active, input assigned);
    modport eval (input sig, input sel, input inv, output active, output assigned);
endinterface

//--- logic/lil_trig_eval.sv
// Combines the five trigger slots of one lamp into its active and assigned flags.
`timescale 1ns/1ps
module lil_trig_eval
    import lil_pkg::*;
(
    lil_eval_if.eval bus
);
    logic [SLOTS-1:0] slot_val;
    logic [SLOTS-1:0] slot_used;
    logic [NUM_SIG:0] sig_ext;

    assign sig_ext = {bus.sig, 1'b0};

    genvar s;
    generate
        for (s = 0; s < SLOTS; s++) begin : g_slot
            // An empty slot is a plain zero and its inversion is ignored.
            assign slot_used[s] = (bus.sel[s] != SEL_NONE) && (bus.sel[s] <= SEL_MAX);
            assign slot_val[s] = slot_used[s]
                && (sig_ext[bus.sel[s]] ^ bus.inv[s]);
        end
    endgenerate

    assign bus.active = |slot_val;
    assign bus.assigned = |slot_used;
endmodule

//--- logic/lil_lamp_top.sv
// Indicator lamp logic: trigger combining, latching, acknowledgement and colour drive.
`timescale 1ns/1ps
// Overview of operation
// - A lamp is active when any of its five effective triggers is true.
// - Each trigger slot has its own inversion applied before combining.
// - An unassigned slot always gives zero; its inversion is ignored.
// - In hold mode the lamp keeps its triggered state until a valid clear.
// - In follow mode the lamp tracks its combined triggers without storage.
// - The per-lamp clear source acts only in hold mode, with triggers dropped.
// - An active lamp shows its configured lit code.
// - A lamp neither active nor held shows its separately configured unlit code.
// - A held lamp clears after triggers drop, by the listed causes, or at once when it leaves hold mode or has no slot assigned.
// - Held lamp states survive a restart; the rst reset clears them.
// - Clearing all lamps by signal or remote link needs the remote permit.
// - A protection alarm clears all held lamps when alarm-clear mode is used.
// - The panel clear key clears held lamps once triggers have dropped.
// - Health lamp flashes green while booting, steady green once running.
// - The second column behaves exactly like the first.
// - The health lamp has a fixed function and no settings.
module lil_lamp_top
    import lil_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_HALF_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic boot_done,
    input wire lil_sig_t prot_sig,
    input wire logic prot_alarm,
    input wire logic clear_key_pin,
    input wire logic remote_clear_all,
    input wire logic remote_clear_permit,
    input wire lil_sel_t global_lamp_clear_source,
    input wire lil_sel_t [COLS-1:0][ROWS-1:0][SLOTS-1:0] slot_sel,
    input wire logic [COLS-1:0][ROWS-1:0][SLOTS-1:0] slot_inv,
    input wire lil_mode_t [COLS-1:0][ROWS-1:0] hold_mode,
    input wire lil_sel_t [COLS-1:0][ROWS-1:0] lamp_clear_sel,
    input wire lil_code_t [COLS-1:0][ROWS-1:0] lit_code_on,
    input wire lil_code_t [COLS-1:0][ROWS-1:0] lit_code_off,
    output logic [COLS-1:0][ROWS-1:0] lamp_green,
    output logic [COLS-1:0][ROWS-1:0] lamp_red,
    output logic [COLS-1:0][ROWS-1:0] lamp_held,
    output logic health_green
);
    typedef struct packed {
        logic key_meta;
        logic key_sync;
        logic key_prev;
        logic alarm_prev;
        logic [CNT_W-1:0] flash_cnt;
        logic flash_phase;
        logic [COLS-1:0][ROWS-1:0] held;
        logic [COLS-1:0][ROWS-1:0] green;
        logic [COLS-1:0][ROWS-1:0] red;
        logic health;
    } lil_state_t;

    localparam lil_state_t STATE_RST = '0;
    localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_CYCLES - 1);

    lil_state_t state;
    lil_state_t next_state;

    logic [COLS-1:0][ROWS-1:0] trig_active;
    logic [COLS-1:0][ROWS-1:0] trig_assigned;
    logic [NUM_SIG:0] sig_ext;

    assign sig_ext = {prot_sig, 1'b0};

    genvar c;
    genvar r;
    generate
        for (c = 0; c < COLS; c++) begin : g_col
            for (r = 0; r < ROWS; r++) begin : g_row
                lil_eval_if eval_bus ();
                assign eval_bus.sig = prot_sig;
                assign eval_bus.sel = slot_sel[c][r];
                assign eval_bus.inv = slot_inv[c][r];
                assign trig_active[c][r] = eval_bus.active;
                assign trig_assigned[c][r] = eval_bus.assigned;
                // Both columns use the same evaluator and latch logic.
                lil_trig_eval u_eval (
                    .bus (eval_bus.eval)
                );
            end
        end
    endgenerate

    // Picks a signal from the protection vector; values past the last signal read zero.
    function automatic logic pick_sig(input lil_sel_t sel, input logic [NUM_SIG:0] ext);
        logic bit_val;
        bit_val = 1'b0;
        if (sel <= SEL_MAX) begin
            bit_val = ext[sel];
        end
        return bit_val;
    endfunction

    // Turns a colour code and the flash phase into green and red drive bits.
    function automatic logic [1:0] code_drive(input lil_code_t code, input logic phase);
        logic [1:0] gr;
        gr = 2'h0;
        case (code)
            CODE_GREEN: begin
                gr = 2'h2;
            end
            CODE_RED: begin
                gr = 2'h1;
            end
            CODE_RED_FLASH: begin
                gr = {1'b0, phase};
            end
            CODE_GREEN_FLASH: begin
                gr = {phase, 1'b0};
            end
            default: begin
                gr = 2'h0;
            end
        endcase
        return gr;
    endfunction

    always_comb begin
        logic key_press;
        logic alarm_rise;
        logic alarm_mode_used;
        logic clear_all;
        logic clear_this;
        logic holding;
        logic shown;
        logic [1:0] drive;
        key_press = 1'b0;
        alarm_rise = 1'b0;
        alarm_mode_used = 1'b0;
        clear_all = 1'b0;
        clear_this = 1'b0;
        holding = 1'b0;
        shown = 1'b0;
        drive = 2'h0;
        next_state = state;

        // The panel key is a pin: two flip-flops before the edge detector.
        next_state.key_meta = clear_key_pin;
        next_state.key_sync = state.key_meta;
        next_state.key_prev = state.key_sync;
        key_press = state.key_sync && !state.key_prev;

        next_state.alarm_prev = prot_alarm;
        alarm_rise = prot_alarm && !state.alarm_prev;

        for (int ci = 0; ci < COLS; ci++) begin
            for (int ri = 0; ri < ROWS; ri++) begin
                if (hold_mode[ci][ri] == MODE_HOLD_ALARM) begin
                    alarm_mode_used = 1'b1;
                end
            end
        end

        // Group clears; key and alarm requests are one-cycle edges, and no request is remembered.
        clear_all = key_press;
        if (remote_clear_permit) begin
            clear_all = clear_all || remote_clear_all
                || pick_sig(global_lamp_clear_source, sig_ext);
        end
        if (alarm_mode_used && alarm_rise) begin
            clear_all = 1'b1;
        end

        // Flash timebase shared by all flashing codes and the health lamp.
        if (state.flash_cnt >= FLASH_LAST) begin
            next_state.flash_cnt = '0;
            next_state.flash_phase = !state.flash_phase;
        end else begin
            next_state.flash_cnt = state.flash_cnt + CNT_W'(1);
        end

        for (int ci = 0; ci < COLS; ci++) begin
            for (int ri = 0; ri < ROWS; ri++) begin
                holding = (hold_mode[ci][ri] == MODE_HOLD)
                    || (hold_mode[ci][ri] == MODE_HOLD_ALARM);
                clear_this = clear_all;
                if (holding && pick_sig(lamp_clear_sel[ci][ri], sig_ext)) begin
                    clear_this = 1'b1;
                end
                if (!holding || !trig_assigned[ci][ri]) begin
                    next_state.held[ci][ri] = 1'b0;
                end else if (trig_active[ci][ri]) begin
                    // A clear with triggers still active is simply dropped.
                    next_state.held[ci][ri] = 1'b1;
                end else if (clear_this) begin
                    next_state.held[ci][ri] = 1'b0;
                end
                shown = trig_active[ci][ri] || (holding && state.held[ci][ri]);
                if (shown) begin
                    drive = code_drive(lit_code_on[ci][ri], state.flash_phase);
                end else begin
                    drive = code_drive(lit_code_off[ci][ri], state.flash_phase);
                end
                next_state.green[ci][ri] = drive[1];
                next_state.red[ci][ri] = drive[0];
            end
        end

        // Fixed health indication with no settings of its own.
        if (boot_done) begin
            next_state.health = 1'b1;
        end else begin
            next_state.health = state.flash_phase;
        end

        // A restart reboots the timebase and indication but keeps held lamps.
        if (restart) begin
            next_state.flash_cnt = '0;
            next_state.flash_phase = 1'b0;
            next_state.green = '0;
            next_state.red = '0;
            next_state.health = 1'b0;
            next_state.held = state.held;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= STATE_RST;
        end else begin
            state <= next_state;
        end
    end

    assign lamp_green = state.green;
    assign lamp_red = state.red;
    assign lamp_held = state.held;
    assign health_green = state.health;
endmodule

//--- verification/lil_lamp_properties.sv
// Checker with concurrent assertions on the lamp logic top ports.
`timescale 1ns/1ps
module lil_lamp_properties
    import lil_pkg::*;
#(
    parameter int FLASH_CYCLES = 4
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic boot_done,
    input wire lil_mode_t [COLS-1:0][ROWS-1:0] hold_mode,
    input wire lil_code_t [COLS-1:0][ROWS-1:0] lit_code_on,
    input wire lil_code_t [COLS-1:0][ROWS-1:0] lit_code_off,
    input wire logic [COLS-1:0][ROWS-1:0] lamp_green,
    input wire logic [COLS-1:0][ROWS-1:0] lamp_red,
    input wire logic [COLS-1:0][ROWS-1:0] lamp_held,
    input wire logic health_green
);
    // Counts cycles since the health lamp last changed while the device boots.
    // The lamp is registered from the flash phase, so its first half period after
    // a reset or a restart is one cycle longer; that cycle is skipped here.
    logic [31:0] h_cnt;
    logic h_skip;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            h_cnt <= '0;
            h_skip <= 1'b1;
        end else if (boot_done || restart || $changed(health_green)) begin
            h_cnt <= '0;
            h_skip <= restart;
        end else if (h_skip) begin
            h_skip <= 1'b0;
        end else begin
            h_cnt <= h_cnt + 32'h0000_0001;
        end
    end
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_follow_no_hold: assert property (hold_mode[0][0] == MODE_FOLLOW |=> !lamp_held[0][0])
        else $error("held set in follow mode");
    a_dark_off: assert property (lit_code_on[0][2] == CODE_OFF &&
        lit_code_off[0][2] == CODE_OFF |=> !lamp_green[0][2] && !lamp_red[0][2])
        else $error("dark lamp lit");
    a_green_steady: assert property (lit_code_on[0][1] == CODE_GREEN && !restart &&
        lit_code_off[0][1] == CODE_GREEN |=> lamp_green[0][1] && !lamp_red[0][1])
        else $error("green lamp wrong");
    a_red_steady: assert property (lit_code_on[1][1] == CODE_RED && !restart &&
        lit_code_off[1][1] == CODE_RED |=> lamp_red[1][1] && !lamp_green[1][1])
        else $error("red lamp wrong");
    a_restart_dark: assert property (restart |=> !health_green && lamp_red == '0)
        else $error("drive not cleared on restart");
    a_health_steady: assert property (boot_done && !restart |=> health_green)
        else $error("health lamp not steady");
    a_flash_period: assert property (!boot_done |-> h_cnt <= FLASH_CYCLES)
        else $error("health lamp not flashing");
    a_held_shows_on: assert property (lamp_held[0][0] && !restart &&
        hold_mode[0][0] == MODE_HOLD && lit_code_on[0][0] == CODE_RED ##1 lamp_held[0][0]
        |-> lamp_red[0][0]) else $error("held lamp not lit");
    cover property (lamp_held[0][0] ##1 !lamp_held[0][0]);
    cover property (restart ##1 lamp_held[0][0]);
    cover property (boot_done && health_green);
endmodule

//--- verification/lil_prot_src.sv
// Behavioural source of the protection signals and the protection alarm.
`timescale 1ns/1ps
module lil_prot_src
    import lil_pkg::*;
(
    input wire lil_sig_t want,
    input wire logic alarm_req,
    output lil_sig_t prot_sig,
    output logic prot_alarm
);
    assign prot_sig = want;
    assign prot_alarm = alarm_req;
endmodule

//--- verification/lil_lamp_top_tb.sv
// Self-checking bench for the indicator lamp logic.
`timescale 1ns/1ps
module lil_lamp_top_tb;
    import lil_pkg::*;
    localparam int FLASH = 4;
    logic sys_clk, rst, restart, boot_done, alarm_req, prot_alarm, clear_key_pin;
    logic remote_clear_all, remote_clear_permit, health_green, h0;
    lil_sig_t want, prot_sig;
    lil_sel_t global_lamp_clear_source;
    lil_sel_t [COLS-1:0][ROWS-1:0][SLOTS-1:0] slot_sel;
    logic [COLS-1:0][ROWS-1:0][SLOTS-1:0] slot_inv;
    lil_mode_t [COLS-1:0][ROWS-1:0] hold_mode;
    lil_sel_t [COLS-1:0][ROWS-1:0] lamp_clear_sel;
    lil_code_t [COLS-1:0][ROWS-1:0] lit_code_on, lit_code_off;
    logic [COLS-1:0][ROWS-1:0] lamp_green, lamp_red, lamp_held;
    int err_count = 0;
    int total_checks = 0;
    int i;
    typedef struct {lil_sig_t s; logic [4:0] v; logic a;} lil_row_t;
    lil_row_t rows[6] = '{'{32'h0000_0000, 5'h00, 1'h0}, '{32'h0000_0008, 5'h00, 1'h1},
        '{32'h0000_0001, 5'h00, 1'h1}, '{32'h0000_0000, 5'h02, 1'h1},
        '{32'h0000_000F, 5'h0F, 1'h0}, '{32'h0000_0010, 5'h10, 1'h0}};
    lil_prot_src src (.want(want), .alarm_req(alarm_req), .prot_sig(prot_sig),
        .prot_alarm(prot_alarm));
    lil_lamp_top #(.FLASH_CYCLES(FLASH)) dut (.*);
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic step(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(string nm, logic e, logic g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic lamp(int c, logic h, logic r);
        chk("held", h, lamp_held[c][0]);
        chk("red", r, lamp_red[c][0]);
        chk("green", !r, lamp_green[c][0]);
    endtask
    // Sets the latch with one trigger cycle, then lets the trigger drop.
    task automatic arm();
        want[0] = 1'h1;
        step(1);
        want[0] = 1'h0;
        step(2);
    endtask
    task automatic pulse_sig(int b);
        want[b] = 1'h1;
        step(1);
        want[b] = 1'h0;
        step(1);
    endtask
    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #(3000 * 100);
        err_count++;
        print_verdict();
    end
    initial begin
        {rst, restart, boot_done, alarm_req, clear_key_pin, remote_clear_all} = 6'h20;
        remote_clear_permit = 1'h0;
        want = '0;
        global_lamp_clear_source = SEL_NONE;
        {slot_sel, slot_inv, hold_mode, lamp_clear_sel, lit_code_on, lit_code_off} = '0;
        for (i = 0; i < COLS; i++) begin
            slot_sel[i][0] = {SEL_NONE, 6'h04, 6'h03, 6'h02, 6'h01};
            lit_code_on[i][0] = CODE_RED;
            lit_code_off[i][0] = CODE_GREEN;
        end
        lit_code_on[0][1] = CODE_GREEN;
        lit_code_off[0][1] = CODE_GREEN;
        lit_code_on[1][1] = CODE_RED;
        lit_code_off[1][1] = CODE_RED;
        lit_code_off[0][3] = CODE_GREEN_FLASH;
        lit_code_off[1][3] = CODE_RED_FLASH;
        step(8);
        rst = 1'h0;
        step(1);
        h0 = health_green;
        i = 0;
        while (health_green === h0 && i < 3 * FLASH) begin
            step(1);
            i++;
        end
        chk("flash", 1'h1, i < 3 * FLASH);
        chk("green flash on", 1'h1, lamp_green[0][3]);
        chk("red flash on", 1'h1, lamp_red[1][3]);
        step(FLASH);
        chk("green flash off", 1'h0, lamp_green[0][3]);
        chk("red flash off", 1'h0, lamp_red[1][3]);
        foreach (rows[k]) begin
            want = rows[k].s;
            slot_inv[0][0] = rows[k].v;
            slot_inv[1][0] = rows[k].v;
            step(2);
            lamp(0, 1'h0, rows[k].a);
            lamp(1, 1'h0, rows[k].a);
        end
        want = '0;
        slot_inv = '0;
        hold_mode[0][0] = MODE_HOLD;
        step(1);
        arm();
        lamp(0, 1'h1, 1'h1);
        remote_clear_all = 1'h1;
        step(1);
        remote_clear_all = 1'h0;
        step(1);
        lamp(0, 1'h1, 1'h1);
        remote_clear_permit = 1'h1;
        want[0] = 1'h1;
        remote_clear_all = 1'h1;
        step(1);
        want[0] = 1'h0;
        remote_clear_all = 1'h0;
        step(3);
        lamp(0, 1'h1, 1'h1);
        global_lamp_clear_source = 6'h08;
        pulse_sig(7);
        lamp(0, 1'h0, 1'h0);
        remote_clear_permit = 1'h0;
        lamp_clear_sel[0][0] = 6'h09;
        arm();
        pulse_sig(8);
        lamp(0, 1'h0, 1'h0);
        arm();
        clear_key_pin = 1'h1;
        step(6);
        clear_key_pin = 1'h0;
        lamp(0, 1'h0, 1'h0);
        arm();
        restart = 1'h1;
        step(1);
        restart = 1'h0;
        step(2);
        lamp(0, 1'h1, 1'h1);
        hold_mode[0][0] = MODE_FOLLOW;
        step(2);
        lamp(0, 1'h0, 1'h0);
        hold_mode[0][0] = MODE_HOLD_ALARM;
        arm();
        alarm_req = 1'h1;
        step(1);
        alarm_req = 1'h0;
        step(1);
        lamp(0, 1'h0, 1'h0);
        hold_mode[0][0] = MODE_HOLD;
        arm();
        slot_sel[0][0] = '0;
        step(2);
        lamp(0, 1'h0, 1'h0);
        boot_done = 1'h1;
        step(2);
        chk("health", 1'h1, health_green);
        step(10);
        chk("health", 1'h1, health_green);
        print_verdict();
    end
endmodule
bind lil_lamp_top lil_lamp_properties #(.FLASH_CYCLES(FLASH_CYCLES)) props (.*);
